// ==== verilog/pmrc_pkg.sv ====
// Constants, register map and carriers for the power-mode and reset controller.
// Assumes a single 40 MHz system clock and a byte-addressed Avalon-MM slave.
package pmrc_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int RST_HOLD_NS   = 1000;
   localparam logic [5:0] RST_HOLD_CYC = 6'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Register byte offsets
   localparam logic [5:0] OFS_CTRL      = 6'h00;
   localparam logic [5:0] OFS_PERIPH_EN = 6'h04;
   localparam logic [5:0] OFS_STATUS    = 6'h08;
   localparam logic [5:0] OFS_RST_FLAGS = 6'h0C;

   // Control register fields
   localparam int CTRL_SEL_LO     = 0;
   localparam int CTRL_SEL_HI     = 1;
   localparam int CTRL_SLEEP_EXIT = 2;
   localparam int CTRL_DEEP       = 3;
   localparam int CTRL_SLOW_INT   = 4;
   localparam int CTRL_SLOW_XTAL  = 5;
   localparam int CTRL_SOFT_RST   = 6;
   localparam logic [5:0] CTRL_RST       = 6'h30;
   localparam logic [7:0] PERIPH_EN_RST  = 8'hFF;
   localparam logic [4:0] RST_FLAGS_RST  = 5'h01;

   // Reset flag bits
   localparam int FLG_POWER = 0;
   localparam int FLG_PIN   = 1;
   localparam int FLG_WDT   = 2;
   localparam int FLG_SOFT  = 3;
   localparam int FLG_LOCK  = 4;

   // Clock select codes
   localparam logic [1:0] SEL_FAST = 2'h0;
   localparam logic [1:0] SEL_EXT  = 2'h1;

   // Synchronised pin vector layout
   localparam int PIN_W       = 11;
   localparam int P_EXT_RST_N = 0;
   localparam int P_POR_OK    = 1;
   localparam int P_REG_RDY   = 2;
   localparam int P_PDR_TRIP  = 3;
   localparam int P_WAKE_LO   = 4;
   localparam int P_WAKE_HI   = 7;
   localparam int P_FAST_RDY  = 8;
   localparam int P_EXT_RDY   = 9;
   localparam int P_SLOW_RDY  = 10;
   localparam logic [10:0] PIN_RST = 11'h001;

   localparam logic [31:0] RESET_VECTOR = 32'h0000_0004;
   localparam logic [3:0]  PDR_LEVEL_DEF = 4'h8;

   typedef enum logic [4:0] {
      ST_RUN     = 5'h01,
      ST_LPRUN   = 5'h02,
      ST_SLEEP   = 5'h04,
      ST_LPSLEEP = 5'h08,
      ST_STOP    = 5'h10
   } pmrc_state_t;

   typedef struct packed {
      logic wait_for_interrupt_instr;
      logic wait_for_event_instr;
      logic handler_return;
      logic irq_pending;
      logic wake_event;
      logic interrupt_mask_flag;
      logic lockup;
      logic periph_wake;
   } pmrc_core_t;

   typedef struct packed {
      logic       ahb_clk_en;
      logic       sys_clk_en;
      logic [1:0] src_sel;
      logic       fast_osc_en;
      logic       slow_int_osc_en;
      logic       slow_xtal_osc_en;
      logic       stop_domain_en;
   } pmrc_clk_t;
endpackage

// ==== verilog/pmrc_top.sv ====
// Power-mode sequencer, clock gating, reset generation and register slave.
// Assumes core strobes are on clk_sys; pins and oscillator ready flags are asynchronous.
//
// Behaviour
// - Reset lands in run mode on the fast oscillator, select code zero.
// - Sleep gates the AHB clock; APB and core peripherals keep running.
// - Wait-for-interrupt or handler return sleeps until interrupt; wait-for-event until event.
// - Select upper bit one means low-power run on slow clock; zero leaves it.
// - Low-power sleep is slow clock plus sleep entry; wake keeps the clock.
// - Sleep-after-handler flag sends the core to sleep on handler return.
// - Sleep is left only on a sufficient-priority exception or chosen event.
// - Masked interrupts still wake the core but their handler is held back.
// - Deep-sleep plus entry stops clocks and fast oscillator; wake restarts fast.
// - Per-peripheral enable bits gate each peripheral clock.
// - Software can switch off both slow oscillators.
// - Core memories only in run modes; stop-domain peripherals off in stop.
// - Two reset classes are produced: power reset and system reset.
// - System reset spares debug and real-time clock, which take power reset only.
// - Power reset returns every register to its reset value.
// - Power reset releases only once the core regulator reports ready.
// - The reset handler vector address is a fixed constant.
// - System reset from power, pin, watchdog, soft request or lockup.
// - Clock mux switches only to a ready source and reports the active one.
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module pmrc_top
#(
   parameter logic [3:0] PDR_LEVEL = pmrc_pkg::PDR_LEVEL_DEF
)
(
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   // Avalon-MM slave
   input  wire logic [5:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   // Core and peripheral events
   input  wire pmrc_pkg::pmrc_core_t  core_in,
   input  wire logic                  watchdog_timeout,
   // Asynchronous pins and detectors
   input  wire logic                  ext_reset_pin_n,
   input  wire logic                  supply_rise_ok,
   input  wire logic                  regulator_ready,
   input  wire logic                  supply_fall_trip,
   input  wire logic [3:0]            external_line_interrupts,
   input  wire logic [2:0]            osc_ready,
   // Clock and domain control
   output pmrc_pkg::pmrc_clk_t        clk_out,
   output logic [7:0]                 periph_clk_en,
   output logic                       irq_take,
   // Resets
   output logic                       power_rst_n,
   output logic                       sys_rst_n,
   output logic [31:0]                reset_vector,
   output logic [3:0]                 pdr_threshold
);
   import pmrc_pkg::*;

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] s1_reg;
   logic [PIN_W-1:0] s2_reg;
   logic [PIN_W-1:0] s3_reg;
   logic [PIN_W-1:0] pin_reg;
   pmrc_state_t      state_reg;
   pmrc_state_t      state_next;
   logic [5:0]       ctrl_reg;
   logic [7:0]       periph_en_reg;
   logic [4:0]       flags_reg;
   logic [1:0]       sel_active_reg;
   logic [1:0]       sel_next;
   logic             wake_on_event_reg;
   logic             soft_req_reg;
   logic [5:0]       hold_cnt_reg;
   logic             power_rst_n_reg;
   logic             sys_rst_n_reg;
   pmrc_clk_t        clk_out_reg;
   logic [7:0]       periph_clk_reg;
   logic             irq_take_reg;
   logic [31:0]      rdata_reg;
   logic             wait_reg;
   logic [31:0]      rd_val;
   logic             bus_req;
   logic             wr_fire;
   logic             awake;
   logic             enter;
   logic             stop_wake;
   logic             sleep_wake;
   logic             target_ready;
   logic             sys_src;
   logic [4:0]       flag_set;

   assign pin_raw = {osc_ready[2], osc_ready[1], osc_ready[0], external_line_interrupts,
                     supply_fall_trip, regulator_ready, supply_rise_ok, ext_reset_pin_n};

   // Three-stage sync; the filtered level moves only when stages two and three agree
   genvar i;
   generate
      for (i = 0; i < PIN_W; i++)
      begin : g_sync
         always_ff @(posedge clk_sys)
         begin
            if (!rst_n)
            begin
               s1_reg[i]  <= PIN_RST[i];
               s2_reg[i]  <= PIN_RST[i];
               s3_reg[i]  <= PIN_RST[i];
               pin_reg[i] <= PIN_RST[i];
            end
            else
            begin
               s1_reg[i] <= pin_raw[i];
               s2_reg[i] <= s1_reg[i];
               s3_reg[i] <= s2_reg[i];
               if (s2_reg[i] == s3_reg[i])
                  pin_reg[i] <= s3_reg[i];
            end
         end
      end
   endgenerate

   // Mode sequencing
   assign awake      = (state_reg == ST_RUN) || (state_reg == ST_LPRUN);
   assign enter      = core_in.wait_for_interrupt_instr || core_in.wait_for_event_instr ||
                       (core_in.handler_return && ctrl_reg[CTRL_SLEEP_EXIT]);
   // Only exceptions able to enter a handler count, masked or not
   assign sleep_wake = wake_on_event_reg ? core_in.wake_event : core_in.irq_pending;
   assign stop_wake  = (|pin_reg[P_WAKE_HI:P_WAKE_LO]) || core_in.periph_wake;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN, ST_LPRUN:
         begin
            if (enter && ctrl_reg[CTRL_DEEP])
               state_next = ST_STOP;
            else if (enter)
               state_next = sel_active_reg[1] ? ST_LPSLEEP : ST_SLEEP;
            else
               state_next = sel_active_reg[1] ? ST_LPRUN : ST_RUN;
         end
         ST_SLEEP, ST_LPSLEEP:
         begin
            if (sleep_wake)
               state_next = sel_active_reg[1] ? ST_LPRUN : ST_RUN;
         end
         ST_STOP:
         begin
            if (stop_wake)
               state_next = ST_RUN;
         end
         default:
            state_next = ST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_reg         <= ST_RUN;
         wake_on_event_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (awake && enter)
            wake_on_event_reg <= core_in.wait_for_event_instr;
      end
   end

   // Clock mux: requested source is taken once it reports ready
   always_comb
   begin
      case (ctrl_reg[CTRL_SEL_HI:CTRL_SEL_LO])
         SEL_FAST: target_ready = pin_reg[P_FAST_RDY];
         SEL_EXT:  target_ready = pin_reg[P_EXT_RDY];
         default:  target_ready = pin_reg[P_SLOW_RDY];
      endcase
      sel_next = target_ready ? ctrl_reg[CTRL_SEL_HI:CTRL_SEL_LO] : sel_active_reg;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         sel_active_reg <= SEL_FAST;
      else
         sel_active_reg <= sel_next;
   end

   // Gating outputs follow the next state so they line up with state_reg
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         clk_out_reg.ahb_clk_en       <= 1'b1;
         clk_out_reg.sys_clk_en       <= 1'b1;
         clk_out_reg.src_sel          <= SEL_FAST;
         clk_out_reg.fast_osc_en      <= 1'b1;
         clk_out_reg.slow_int_osc_en  <= CTRL_RST[CTRL_SLOW_INT];
         clk_out_reg.slow_xtal_osc_en <= CTRL_RST[CTRL_SLOW_XTAL];
         clk_out_reg.stop_domain_en   <= 1'b1;
         periph_clk_reg               <= PERIPH_EN_RST;
      end
      else
      begin
         clk_out_reg.ahb_clk_en       <= (state_next == ST_RUN) || (state_next == ST_LPRUN);
         clk_out_reg.sys_clk_en       <= state_next != ST_STOP;
         clk_out_reg.src_sel          <= sel_next;
         clk_out_reg.fast_osc_en      <= state_next != ST_STOP;
         clk_out_reg.slow_int_osc_en  <= ctrl_reg[CTRL_SLOW_INT];
         clk_out_reg.slow_xtal_osc_en <= ctrl_reg[CTRL_SLOW_XTAL];
         clk_out_reg.stop_domain_en   <= state_next != ST_STOP;
         // Stop-domain peripherals lose their clock in stop regardless of enables
         periph_clk_reg <= (state_next == ST_STOP) ? 8'h00 : periph_en_reg;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         irq_take_reg <= 1'b0;
      else
         irq_take_reg <= core_in.irq_pending && !core_in.interrupt_mask_flag;
   end

   // Reset generation
   assign sys_src = !power_rst_n_reg || !pin_reg[P_EXT_RST_N] || watchdog_timeout ||
                    soft_req_reg || core_in.lockup;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         power_rst_n_reg <= 1'b0;
         sys_rst_n_reg   <= 1'b0;
         hold_cnt_reg    <= RST_HOLD_CYC;
      end
      else
      begin
         // Regulator ready gates release; a supply-fall trip pulls it back at once
         power_rst_n_reg <= pin_reg[P_POR_OK] && pin_reg[P_REG_RDY] && !pin_reg[P_PDR_TRIP];
         if (sys_src)
            hold_cnt_reg <= RST_HOLD_CYC;
         else if (hold_cnt_reg != 6'h00)
            hold_cnt_reg <= hold_cnt_reg - 6'h01;
         sys_rst_n_reg <= !sys_src && (hold_cnt_reg == 6'h00);
      end
   end

   // Avalon slave: one wait cycle, then the access completes
   assign bus_req = avs_read || avs_write;
   assign wr_fire = avs_write && !wait_reg && avs_byteenable[0];

   always_comb
   begin
      case (avs_address)
         OFS_CTRL:      rd_val = {26'h000_0000, ctrl_reg};
         OFS_PERIPH_EN: rd_val = {24'h00_0000, periph_en_reg};
         OFS_STATUS:    rd_val = {24'h00_0000, clk_out_reg.fast_osc_en, sel_active_reg, state_reg};
         OFS_RST_FLAGS: rd_val = {27'h000_0000, flags_reg};
         default:       rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         if (bus_req && wait_reg)
         begin
            wait_reg  <= 1'b0;
            rdata_reg <= rd_val;
         end
         else
            wait_reg <= 1'b1;
      end
   end

   // Registers return to reset values only under power reset
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         ctrl_reg      <= CTRL_RST;
         periph_en_reg <= PERIPH_EN_RST;
         soft_req_reg  <= 1'b0;
      end
      else
      begin
         soft_req_reg <= wr_fire && (avs_address == OFS_CTRL) && avs_writedata[CTRL_SOFT_RST];
         if (state_reg == ST_STOP && stop_wake)
            ctrl_reg[CTRL_SEL_HI:CTRL_SEL_LO] <= SEL_FAST;
         else if (wr_fire && avs_address == OFS_CTRL)
            ctrl_reg <= avs_writedata[5:0];
         if (wr_fire && avs_address == OFS_PERIPH_EN)
            periph_en_reg <= avs_writedata[7:0];
      end
   end

   // Sticky reset causes; a new cause beats a write-one clear
   assign flag_set = {core_in.lockup, soft_req_reg, watchdog_timeout,
                      !pin_reg[P_EXT_RST_N], !power_rst_n_reg};

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         flags_reg <= RST_FLAGS_RST;
      else if (wr_fire && avs_address == OFS_RST_FLAGS)
         flags_reg <= (flags_reg & ~avs_writedata[4:0]) | flag_set;
      else
         flags_reg <= flags_reg | flag_set;
   end

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign clk_out         = clk_out_reg;
   assign periph_clk_en   = periph_clk_reg;
   assign irq_take        = irq_take_reg;
   assign power_rst_n     = power_rst_n_reg;
   assign sys_rst_n       = sys_rst_n_reg;
   assign reset_vector    = RESET_VECTOR;
   assign pdr_threshold   = PDR_LEVEL;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   property p_reset_run;
      $rose(rst_n) |-> state_reg == ST_RUN && clk_out_reg.src_sel == SEL_FAST && clk_out_reg.fast_osc_en;
   endproperty
   a_reset_run: assert property (p_reset_run) else $error("not in fast run after reset");

   property p_sleep_gate;
      (state_reg == ST_SLEEP || state_reg == ST_LPSLEEP) |-> !clk_out_reg.ahb_clk_en && clk_out_reg.sys_clk_en;
   endproperty
   a_sleep_gate: assert property (p_sleep_gate) else $error("bus clock live in sleep");

   property p_wfi_sleep;
      state_reg == ST_RUN && core_in.wait_for_interrupt_instr && !ctrl_reg[CTRL_DEEP] && !sel_active_reg[1] |=> state_reg == ST_SLEEP;
   endproperty
   a_wfi_sleep: assert property (p_wfi_sleep) else $error("no sleep after wait");

   property p_exit_sleep;
      awake && core_in.handler_return && ctrl_reg[CTRL_SLEEP_EXIT] |=> !awake;
   endproperty
   a_exit_sleep: assert property (p_exit_sleep) else $error("handler return did not sleep");

   property p_stay_asleep;
      state_reg == ST_SLEEP && !sleep_wake |=> state_reg == ST_SLEEP;
   endproperty
   a_stay_asleep: assert property (p_stay_asleep) else $error("sleep left without wake");

   property p_lp_keep;
      state_reg == ST_LPSLEEP && sleep_wake && sel_active_reg[1] |=> state_reg == ST_LPRUN;
   endproperty
   a_lp_keep: assert property (p_lp_keep) else $error("slow clock lost on wake");

   property p_mask_defer;
      core_in.irq_pending && core_in.interrupt_mask_flag |=> !irq_take_reg;
   endproperty
   a_mask_defer: assert property (p_mask_defer) else $error("masked handler taken");

   property p_stop_osc;
      state_reg == ST_STOP |-> !clk_out_reg.fast_osc_en && periph_clk_reg == 8'h00;
   endproperty
   a_stop_osc: assert property (p_stop_osc) else $error("clocks live in stop");

   property p_wdt_reset;
      watchdog_timeout |=> !sys_rst_n_reg ##1 !sys_rst_n_reg [*8];
   endproperty
   a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog did not hold reset");

   property p_mux_ready;
      clk_out_reg.src_sel != $past(clk_out_reg.src_sel) |-> $past(target_ready);
   endproperty
   a_mux_ready: assert property (p_mux_ready) else $error("switched to unready source");

   property p_reg_ready;
      $rose(power_rst_n_reg) |-> $past(pin_reg[P_REG_RDY]);
   endproperty
   a_reg_ready: assert property (p_reg_ready) else $error("power reset released early");
endmodule

// ==== testbench/pmrc_far_model.sv ====
// Far-side model: oscillators and core regulator answering the controller's enables.
// Assumes one clock; slow oscillators report ready at once, the fast one two cycles after enable.
`timescale 1ns/1ps
module pmrc_far_model
(
   // Clock
   input  wire logic                clk_sys,
   // Controls from the block and the bench
   input  wire pmrc_pkg::pmrc_clk_t clk_out,
   input  wire logic                ext_present,
   input  wire logic                supply_rise_ok,
   // Ready flags
   output logic [2:0]               osc_ready,
   output logic                     regulator_ready
);
   import pmrc_pkg::*;
   logic [1:0] fast_dly_reg = 2'h0;
   logic [3:0] reg_cnt_reg  = 4'h0;
   // Start-up delay, so no switch can lean on an instant ready
   always_ff @(posedge clk_sys)
   begin
      fast_dly_reg <= {fast_dly_reg[0], clk_out.fast_osc_en};
   end
   // Regulator ramps 15 cycles after supply good
   always_ff @(posedge clk_sys)
   begin
      if (!supply_rise_ok)
         reg_cnt_reg <= 4'h0;
      else if (reg_cnt_reg != 4'hF)
         reg_cnt_reg <= reg_cnt_reg + 4'h1;
   end
   assign regulator_ready = (reg_cnt_reg == 4'hF);
   // Slow clock ready while either slow oscillator runs
   assign osc_ready = {clk_out.slow_int_osc_en | clk_out.slow_xtal_osc_en, ext_present, fast_dly_reg[1]};
endmodule

// ==== testbench/pmrc_top_tb_top.sv ====
// Self-checking bench for the power-mode and reset controller.
// Assumes the far-side model supplies oscillator and regulator ready flags.
`timescale 1ns/1ps
module pmrc_top_tb_top;
   import pmrc_pkg::*;
   localparam logic [3:0] PDR_TB = 4'h5;
   localparam logic [7:0] M_WFI = 8'h80, M_WFE = 8'h40, M_RET = 8'h20, M_IRQ = 8'h10;
   localparam logic [7:0] M_EVT = 8'h08, M_LOCK = 8'h02, M_PWK = 8'h01;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [5:0]  avs_address = 6'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   pmrc_core_t  core_s = '0;
   logic        wdt = 1'b0;
   logic        pin_n = 1'b1;
   logic        supply_ok = 1'b1;
   logic        fall_trip = 1'b0;
   logic [3:0]  ext_lines = 4'h0;
   logic        ext_present = 1'b1;
   logic [2:0]  osc_ready;
   logic        regulator_ready;
   pmrc_clk_t   clk_out;
   logic [7:0]  periph_clk_en;
   logic        irq_take, power_rst_n, sys_rst_n;
   logic [31:0] reset_vector;
   logic [3:0]  pdr_threshold;
   int          num_errors = 0;
   int          n_compared = 0;
   int          n, k;
   logic [31:0] q_unused;

   always #12.5 clk_sys = ~clk_sys;

   pmrc_top #(.PDR_LEVEL(PDR_TB)) pmrc_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_in(core_s), .watchdog_timeout(wdt),
      .ext_reset_pin_n(pin_n), .supply_rise_ok(supply_ok), .regulator_ready(regulator_ready),
      .supply_fall_trip(fall_trip), .external_line_interrupts(ext_lines), .osc_ready(osc_ready),
      .clk_out(clk_out), .periph_clk_en(periph_clk_en), .irq_take(irq_take), .power_rst_n(power_rst_n),
      .sys_rst_n(sys_rst_n), .reset_vector(reset_vector), .pdr_threshold(pdr_threshold));

   pmrc_far_model pmrc_far_model_inst (.clk_sys(clk_sys), .clk_out(clk_out), .ext_present(ext_present),
      .supply_rise_ok(supply_ok), .osc_ready(osc_ready), .regulator_ready(regulator_ready));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask

   // One access; waitrequest and read data are taken at the same edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int i;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk_sys);
         if (avs_waitrequest === 1'b0)
            break;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i == 20)
      begin
         check("waitrequest timeout", 32'h0000_0001, 32'h0000_0000);
         end_sim();
      end
      #1;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hF, q);
   endtask

   task automatic rd(input string what, input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, 4'hF, q);
      check(what, q, exp);
   endtask

   // One-cycle core strobe; the block samples it at the second edge
   task automatic pulse(input logic [7:0] m);
      @(posedge clk_sys);
      core_s <= pmrc_core_t'(core_s | m);
      @(posedge clk_sys);
      core_s <= pmrc_core_t'(core_s & ~m);
      #1;
   endtask

   task automatic wait_sys(input int lim);
      n = 0;
      while (sys_rst_n !== 1'b1 && n < lim)
      begin
         cyc(1);
         n++;
      end
      if (n == lim)
      begin
         check("reset release timeout", 32'h0000_0001, 32'h0000_0000);
         end_sim();
      end
   endtask

   task automatic do_reset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      cyc(10);
      rst_n <= 1'b1;
      wait_sys(200);
   endtask

   initial
   begin
      cyc(10);
      rst_n <= 1'b1;
      wait_sys(200);
      check("clk_out", 32'(clk_out), 32'h0000_00CF);
      check("periph_clk_en", 32'(periph_clk_en), 32'h0000_00FF);
      check("reset_vector", reset_vector, 32'h0000_0004);
      check("pdr_threshold", 32'(pdr_threshold), 32'(PDR_TB));
      check("power_rst_n", 32'(power_rst_n), 32'h0000_0001);
      rd("ctrl", OFS_CTRL, 32'h0000_0030);
      rd("status", OFS_STATUS, 32'h0000_0081);
      rd("flags", OFS_RST_FLAGS, 32'h0000_0001);
      wr(OFS_STATUS, 32'h0000_0000);
      rd("status ro", OFS_STATUS, 32'h0000_0081);
      wr(6'h10, 32'h0000_00FF);
      rd("unmapped", 6'h10, 32'h0000_0000);
      $display("test registers done");
      // Sleep entries and their own wake sources
      pulse(M_WFI);
      check("ahb sleep", 32'({clk_out.ahb_clk_en, clk_out.sys_clk_en}), 32'h0000_0001);
      pulse(M_EVT);
      check("event no wake", 32'(clk_out.ahb_clk_en), 32'h0000_0000);
      pulse(M_IRQ);
      check("irq wake", 32'(clk_out.ahb_clk_en), 32'h0000_0001);
      pulse(M_WFE);
      pulse(M_IRQ);
      check("irq no wake", 32'(clk_out.ahb_clk_en), 32'h0000_0000);
      pulse(M_EVT);
      check("event wake", 32'(clk_out.ahb_clk_en), 32'h0000_0001);
      pulse(M_RET);
      check("return flag off", 32'(clk_out.ahb_clk_en), 32'h0000_0001);
      wr(OFS_CTRL, 32'h0000_0034);
      pulse(M_RET);
      check("return sleeps", 32'(clk_out.ahb_clk_en), 32'h0000_0000);
      pulse(M_IRQ);
      @(posedge clk_sys);
      core_s.interrupt_mask_flag <= 1'b1;
      pulse(M_WFI);
      pulse(M_IRQ);
      check("masked wake", 32'({clk_out.ahb_clk_en, irq_take}), 32'h0000_0002);
      @(posedge clk_sys);
      core_s.interrupt_mask_flag <= 1'b0;
      pulse(M_IRQ);
      check("unmasked take", 32'(irq_take), 32'h0000_0001);
      $display("test sleep done");
      // Low-power run and sleep on the slow clock
      wr(OFS_CTRL, 32'h0000_0032);
      cyc(4);
      check("src slow", 32'(clk_out.src_sel), 32'h0000_0002);
      rd("status lprun", OFS_STATUS, 32'h0000_00C2);
      pulse(M_WFI);
      rd("status lpsleep", OFS_STATUS, 32'h0000_00C8);
      pulse(M_IRQ);
      check("wake slow", 32'({clk_out.ahb_clk_en, clk_out.src_sel}), 32'h0000_0006);
      wr(OFS_CTRL, 32'h0000_0030);
      cyc(4);
      rd("status run", OFS_STATUS, 32'h0000_0081);
      ext_present <= 1'b0;
      // Ready flag needs four edges through the pin filter
      cyc(6);
      wr(OFS_CTRL, 32'h0000_0031);
      cyc(6);
      check("no switch unready", 32'(clk_out.src_sel), 32'h0000_0000);
      ext_present <= 1'b1;
      cyc(8);
      rd("status ext", OFS_STATUS, 32'h0000_00A1);
      wr(OFS_CTRL, 32'h0000_0030);
      $display("test clock select done");
      // Stop mode, woken by a line and by a peripheral
      wr(OFS_PERIPH_EN, 32'h0000_005A);
      cyc(1);
      check("periph en", 32'(periph_clk_en), 32'h0000_005A);
      bus(1'b1, OFS_PERIPH_EN, 32'h0000_0000, 4'h0, q_unused);
      rd("be0 ignored", OFS_PERIPH_EN, 32'h0000_005A);
      wr(OFS_CTRL, 32'h0000_0038);
      pulse(M_WFI);
      check("stop clocks", 32'(clk_out), 32'h0000_0006);
      check("stop periph", 32'(periph_clk_en), 32'h0000_0000);
      ext_lines <= 4'h4;
      cyc(8);
      ext_lines <= 4'h0;
      check("stop wake", 32'(clk_out), 32'h0000_00CF);
      // Filtered line must fall first, or it wakes the next stop at once
      cyc(6);
      pulse(M_WFE);
      check("stop again", 32'(clk_out.ahb_clk_en), 32'h0000_0000);
      pulse(M_PWK);
      check("periph wake", 32'(clk_out.ahb_clk_en), 32'h0000_0001);
      wr(OFS_CTRL, 32'h0000_0000);
      cyc(2);
      check("slow osc off", 32'({clk_out.slow_int_osc_en, clk_out.slow_xtal_osc_en}), 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0030);
      $display("test stop done");
      // System reset sources, each flagged, power reset untouched
      wr(OFS_RST_FLAGS, 32'h0000_001F);
      for (k = 0; k < 4; k++)
      begin
         case (k)
            0:
            begin
               @(posedge clk_sys);
               wdt <= 1'b1;
               @(posedge clk_sys);
               wdt <= 1'b0;
            end
            1: pulse(M_LOCK);
            2: wr(OFS_CTRL, 32'h0000_0070);
            default:
            begin
               @(posedge clk_sys);
               pin_n <= 1'b0;
               cyc(8);
               pin_n <= 1'b1;
            end
         endcase
         cyc(6);
         check("sys and power", 32'({sys_rst_n, power_rst_n}), 32'h0000_0001);
         wait_sys(120);
         check("hold long", 32'(n >= 30), 32'h0000_0001);
         rd("flag", OFS_RST_FLAGS, 32'(1) << ((k == 0) ? FLG_WDT : (k == 1) ? FLG_LOCK :
            (k == 2) ? FLG_SOFT : FLG_PIN));
         wr(OFS_RST_FLAGS, 32'h0000_001F);
      end
      $display("test reset sources done");
      // Power reset from the detectors and the regulator
      fall_trip <= 1'b1;
      cyc(8);
      check("power down", 32'({sys_rst_n, power_rst_n}), 32'h0000_0000);
      fall_trip <= 1'b0;
      supply_ok <= 1'b0;
      cyc(4);
      supply_ok <= 1'b1;
      cyc(10);
      check("regulator wait", 32'(power_rst_n), 32'h0000_0000);
      wait_sys(200);
      check("power up", 32'(power_rst_n), 32'h0000_0001);
      wr(OFS_PERIPH_EN, 32'h0000_0033);
      wr(OFS_CTRL, 32'h0000_0002);
      do_reset();
      rd("periph after reset", OFS_PERIPH_EN, 32'h0000_00FF);
      rd("ctrl after reset", OFS_CTRL, 32'h0000_0030);
      $display("test power reset done");
      end_sim();
   end
endmodule
